// >>> inc/asp_pkg.sv
// Package of shared constants and types for the serial command port.
package asp_pkg;
    // ------------------------------------------------------------------
    // Command codes and address map
    // ------------------------------------------------------------------
    localparam logic [7:0] ASP_CMD_WRITE = 8'h0A;
    localparam logic [7:0] ASP_CMD_READ = 8'h0B;
    localparam logic [7:0] ASP_CMD_FIFO = 8'h0D;
    localparam logic [5:0] ASP_ADDR_INVALID = 6'h3F;
    localparam logic [7:0] ASP_ADDR_LIMIT = 8'h3F;
    localparam logic [5:0] ASP_ADDR_USER_LAST = 6'h2E;
    localparam logic [5:0] ASP_DR8_FIRST = 6'h08;
    localparam logic [5:0] ASP_DR8_LAST = 6'h0A;
    localparam logic [5:0] ASP_DR12_FIRST = 6'h0E;
    localparam logic [5:0] ASP_DR12_LAST = 6'h15;
    localparam logic [2:0] ASP_BIT_LAST = 3'h7;
    localparam logic [7:0] ASP_BYTE_ZERO = 8'h00;
    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam int ASP_CLK_MHZ = 50;
    localparam int ASP_DRDY_CLEAR_US = 80;
    localparam int ASP_DRDY_CLEAR_CYC = ASP_DRDY_CLEAR_US * ASP_CLK_MHZ;
    localparam int ASP_SCLK_DIV = 4;
    localparam int ASP_FIFO_DEPTH = 32;
    localparam int ASP_SAMPLE_W = 16;

    // Frame states, Gray coded along command, address, data.
    typedef enum logic [1:0] {
        ASP_ST_CMD = 2'b00,
        ASP_ST_ADDR = 2'b01,
        ASP_ST_DATA = 2'b11,
        ASP_ST_IGNORE = 2'b10
    } asp_state_t;

    // Clamp an incoming address byte onto the 6-bit map.
    function automatic logic [5:0] asp_clamp(input logic [7:0] a);
        asp_clamp = (a > ASP_ADDR_LIMIT) ? ASP_ADDR_INVALID : a[5:0];
    endfunction

    // Next burst address, halting at the invalid location.
    function automatic logic [5:0] asp_incr(input logic [5:0] a);
        asp_incr = (a == ASP_ADDR_INVALID) ? a : a + 6'h01;
    endfunction
endpackage

// >>> inc/asp_if.sv
// Interface joining the serial master and the device command port.
`timescale 1ns/10ps
interface asp_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
    modport mst (output cs_n, output sclk, output mosi, input miso_o, input miso_oe);
endinterface

// >>> hw/asp_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module asp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic do_wr;
    logic do_rd;

    assign in_ready = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // Storage write; pointers wrap since depth is a power of two.
    always_ff @(posedge clock) begin
        if (ce && do_wr) begin
            mem[wp] <= in_data;
        end
    end

    // Pointer and fill level update.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else if (ce) begin
            if (do_wr) begin
                wp <= wp + 1'b1;
            end
            if (do_rd) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // asp_fifo

// >>> hw/asp_dev.sv
// Device end: serial command interpreter with register and sample ports.
`timescale 1ns/10ps
// Summary of operation
// - First byte selects write, read or FIFO.
// - Register frames: command, address, then data.
// - Bursts of many data bytes are accepted.
// - FIFO read has no address byte.
// - Samples are two bytes: axis and data.
// - Odd end drops the sample's upper half.
// - Low byte of each sample goes first.
// - Master should read even byte counts.
// - Master should burst-read results together.
// - FIFO keeps pace with bytes at link rate.
// - Address increments per further data byte.
// - Increment halts at invalid address 63.
// - Addresses above range map to 0x3F.
// - Only 0x00 to 0x2E are user space.
// - Data register reads clear data ready.
// - Data ready clear may lag 80 us.
// - Other accesses have no added latency.
// - Unknown commands are ignored entirely.
// - Output stays undriven after unknown command.
// - Mode 0: sample on rise, shift on fall.
// - Output driven only while returning read data.
module asp_dev
    import asp_pkg::*;
#(
    parameter int DEPTH = ASP_FIFO_DEPTH,
    parameter int CLEAR_CYC = ASP_DRDY_CLEAR_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    asp_if.dev link,
    output logic reg_we,
    output logic reg_re,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [ASP_SAMPLE_W-1:0] smp_data,
    input wire logic smp_valid,
    output logic smp_ready,
    input wire logic drdy_set,
    output logic drdy
);
    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] mosi_sync;
    logic sck_prev;
    logic cs_n;
    logic rise;
    logic fall;

    // Two stages for each pin; only the second stage feeds logic.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_sync <= 2'b11;
            sck_sync <= 2'b00;
            mosi_sync <= 2'b00;
            sck_prev <= 1'b0;
        end else if (ce) begin
            cs_sync <= {cs_sync[0], link.cs_n};
            sck_sync <= {sck_sync[0], link.sclk};
            mosi_sync <= {mosi_sync[0], link.mosi};
            sck_prev <= sck_sync[1];
        end
    end

    assign cs_n = cs_sync[1];
    assign rise = !cs_n && sck_sync[1] && !sck_prev;
    assign fall = !cs_n && !sck_sync[1] && sck_prev;

    // ------------------------------------------------------------------
    // Sample buffer
    // ------------------------------------------------------------------
    logic [ASP_SAMPLE_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_in_ready;

    // The buffer decouples the sensing side from link bursts.
    asp_fifo #(.WIDTH(ASP_SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .in_data(smp_data),
        .in_valid(smp_valid && smp_ready),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Registered ready; it drops for a cycle after each handshake to cover the registered lag.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            smp_ready <= 1'b0;
        end else if (ce) begin
            smp_ready <= fifo_in_ready && !(smp_valid && smp_ready);
        end
    end

    // ------------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------------
    asp_state_t state;
    logic [7:0] cmd;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic [7:0] txreg;
    logic [5:0] addr;
    logic hi_half;
    logic [7:0] rx_byte;
    logic byte_done;
    logic load_tx;

    assign rx_byte = {shreg[6:0], mosi_sync[1]};
    assign byte_done = rise && (bitn == ASP_BIT_LAST);

    // Receive bit counter and shifter; the counter is cleared whenever select is high.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shreg <= ASP_BYTE_ZERO;
            bitn <= 3'h0;
        end else if (ce) begin
            if (cs_n) begin
                bitn <= 3'h0;
            end else if (rise) begin
                shreg <= rx_byte;
                bitn <= bitn + 3'h1;
            end
        end
    end

    // Command, address and state progression.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ASP_ST_CMD;
            cmd <= ASP_BYTE_ZERO;
            addr <= 6'h00;
        end else if (ce) begin
            if (cs_n) begin
                state <= ASP_ST_CMD;
            end else if (byte_done) begin
                case (state)
                    ASP_ST_CMD: begin
                        cmd <= rx_byte;
                        if (rx_byte == ASP_CMD_WRITE || rx_byte == ASP_CMD_READ) begin
                            state <= ASP_ST_ADDR;
                        end else if (rx_byte == ASP_CMD_FIFO) begin
                            state <= ASP_ST_DATA;
                        end else begin
                            state <= ASP_ST_IGNORE;
                        end
                    end
                    ASP_ST_ADDR: begin
                        addr <= asp_clamp(rx_byte);
                        state <= ASP_ST_DATA;
                    end
                    ASP_ST_DATA: begin
                        if (cmd != ASP_CMD_FIFO) begin
                            addr <= asp_incr(addr);
                        end
                    end
                    default: begin
                        state <= ASP_ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Register access strobes, single cycle, no added latency
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            reg_addr <= 6'h00;
            reg_wdata <= ASP_BYTE_ZERO;
        end else if (ce) begin
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            if (byte_done && state == ASP_ST_DATA && cmd == ASP_CMD_WRITE) begin
                reg_we <= (addr != ASP_ADDR_INVALID);
                reg_addr <= addr;
                reg_wdata <= rx_byte;
            end else if (byte_done && cmd == ASP_CMD_READ) begin
                // The address leads the strobe by half a bit, so read data settles first.
                reg_addr <= (state == ASP_ST_ADDR) ? asp_clamp(rx_byte) :
                    asp_incr(addr);
            end else if (load_tx && cmd == ASP_CMD_READ) begin
                reg_re <= (addr != ASP_ADDR_INVALID);
            end
        end
    end

    // Read byte preparation happens on the falling edge ending a byte.
    assign load_tx = fall && bitn == 3'h0 && state == ASP_ST_DATA;
    assign fifo_pop = fifo_valid && hi_half && ((load_tx && cmd == ASP_CMD_FIFO) || cs_n);

    // ------------------------------------------------------------------
    // Output shifter and drive enable
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txreg <= ASP_BYTE_ZERO;
            hi_half <= 1'b0;
            link.miso_oe <= 1'b0;
            link.miso_o <= 1'b0;
        end else if (ce) begin
            if (cs_n) begin
                hi_half <= 1'b0;
                link.miso_oe <= 1'b0;
            end else if (load_tx && cmd == ASP_CMD_READ) begin
                txreg <= {reg_rdata[6:0], 1'b0};
                link.miso_o <= reg_rdata[7];
                link.miso_oe <= 1'b1;
            end else if (load_tx && cmd == ASP_CMD_FIFO) begin
                // Low byte first, then high byte with axis tag.
                if (hi_half) begin
                    txreg <= {fifo_data[14:8], 1'b0};
                    link.miso_o <= fifo_data[15];
                end else begin
                    txreg <= {fifo_data[6:0], 1'b0};
                    link.miso_o <= fifo_data[7];
                end
                hi_half <= !hi_half;
                link.miso_oe <= 1'b1;
            end else if (fall && state == ASP_ST_DATA && cmd != ASP_CMD_WRITE) begin
                link.miso_o <= txreg[7];
                txreg <= {txreg[6:0], 1'b0};
            end else if (state == ASP_ST_IGNORE) begin
                link.miso_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data-ready flag; the clear lands after a fixed delay.
    // ------------------------------------------------------------------
    logic [$clog2(CLEAR_CYC+1)-1:0] clr_cnt;
    logic clr_pend;
    logic dr_hit;

    assign dr_hit = reg_re && ((reg_addr >= ASP_DR8_FIRST && reg_addr <= ASP_DR8_LAST) ||
        (reg_addr >= ASP_DR12_FIRST && reg_addr <= ASP_DR12_LAST));

    // A new set wins over a clear landing in the same cycle; a set during the delay is still cleared.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drdy <= 1'b0;
            clr_pend <= 1'b0;
            clr_cnt <= '0;
        end else if (ce) begin
            if (dr_hit) begin
                clr_pend <= 1'b1;
                clr_cnt <= '0;
            end else if (clr_pend) begin
                clr_cnt <= clr_cnt + 1'b1;
            end
            if (drdy_set) begin
                drdy <= 1'b1;
            end else if (clr_pend && clr_cnt == ($bits(clr_cnt))'(CLEAR_CYC - 1)) begin
                drdy <= 1'b0;
            end
            if (clr_pend && !dr_hit && clr_cnt == ($bits(clr_cnt))'(CLEAR_CYC - 1)) begin
                clr_pend <= 1'b0;
            end
        end
    end
endmodule // asp_dev

// >>> hw/asp_mst.sv
// Master end: issues framed commands and drives the serial clock.
`timescale 1ns/10ps
module asp_mst
    import asp_pkg::*;
#(
    parameter int DIV = ASP_SCLK_DIV
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    asp_if.mst link,
    input wire logic start,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] addr_byte,
    input wire logic [7:0] nbytes,
    input wire logic [7:0] wdata,
    output logic wdata_take,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic busy
);
    // ------------------------------------------------------------------
    // Frame sequencer, mode 0; the clock is divided down locally.
    // ------------------------------------------------------------------
    logic [1:0] miso_sync;
    logic [7:0] div_cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bitn;
    logic [8:0] remain;
    logic hdr2;
    logic phase_hi;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic tick;

    assign tick = (div_cnt == 8'(DIV - 1));

    // Input pin passes two stages before use.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            miso_sync <= 2'b00;
        end else if (ce) begin
            miso_sync <= {miso_sync[0], link.miso_o & link.miso_oe};
        end
    end

    // Byte sequencing: command, optional address, then data bytes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
            busy <= 1'b0;
            div_cnt <= 8'h00;
            tx <= 8'h00;
            rx <= 8'h00;
            bitn <= 3'h0;
            remain <= 9'h000;
            hdr2 <= 1'b0;
            phase_hi <= 1'b0;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
            wdata_take <= 1'b0;
        end else if (ce) begin
            rdata_valid <= 1'b0;
            wdata_take <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    link.cs_n <= 1'b0;
                    cmd_q <= cmd_byte;
                    addr_q <= addr_byte;
                    tx <= {cmd_byte[6:0], 1'b0};
                    link.mosi <= cmd_byte[7];
                    hdr2 <= (cmd_byte != ASP_CMD_FIFO);
                    remain <= {1'b0, nbytes} + 9'h001;
                    bitn <= 3'h0;
                    div_cnt <= 8'h00;
                    phase_hi <= 1'b0;
                end
            end else if (!tick) begin
                div_cnt <= div_cnt + 8'h01;
            end else begin
                div_cnt <= 8'h00;
                phase_hi <= !phase_hi;
                link.sclk <= !phase_hi;
                if (phase_hi) begin
                    // The round trip through both ends' synchronisers outlasts half a
                    // period, so the bit is taken just before the clock falls.
                    rx <= {rx[6:0], miso_sync[1]};
                end
                if (phase_hi && bitn != ASP_BIT_LAST) begin
                    bitn <= bitn + 3'h1;
                    link.mosi <= tx[7];
                    tx <= {tx[6:0], 1'b0};
                end else if (phase_hi) begin
                    bitn <= 3'h0;
                    // Header bytes leave remain above the data count, so only data returns.
                    if (remain <= {1'b0, nbytes}) begin
                        // Read bytes are ignored during writes.
                        rdata <= {rx[6:0], miso_sync[1]};
                        rdata_valid <= (cmd_q != ASP_CMD_WRITE);
                    end
                    if (hdr2) begin
                        hdr2 <= 1'b0;
                        tx <= {addr_q[6:0], 1'b0};
                        link.mosi <= addr_q[7];
                    end else if (remain == 9'h001) begin
                        busy <= 1'b0;
                        link.cs_n <= 1'b1;
                        link.mosi <= 1'b0;
                    end else begin
                        remain <= remain - 9'h001;
                        tx <= {wdata[6:0], 1'b0};
                        link.mosi <= wdata[7];
                        wdata_take <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // asp_mst

// >>> sim/asp_link_asserts.sv
// Checker of the serial link between the master and device ends.
`timescale 1ns/10ps
module asp_link_asserts
    import asp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    logic sclk_q;
    logic rise;
    logic [7:0] rises;
    logic [7:0] cmd_sh;
    assign rise = sclk && !sclk_q;
    // Delayed serial clock, used to find its rising edges.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end
    // Rising edges in the frame; saturates so that long bursts cannot wrap.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) rises <= 8'h00;
        else if (cs_n) rises <= 8'h00;
        else if (rise && rises != 8'hFF) rises <= rises + 8'h01;
    end
    // Command byte as the device should see it, first bit most significant.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) cmd_sh <= 8'h00;
        else if (!cs_n && rise && rises < 8'h08) cmd_sh <= {cmd_sh[6:0], mosi};
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock not idle low");
    property p_mosi_hold; sclk && sclk_q |-> $stable(mosi); endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while clock high");
    property p_high_time; rise |-> sclk [*3]; endproperty
    a_high_time: assert property (p_high_time)
        else $error("serial clock high phase too short");
    property p_miso_shift; miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk; endproperty
    a_miso_shift: assert property (p_miso_shift)
        else $error("miso changed while clock high");
    property p_oe_release; $rose(cs_n) |-> ##[0:5] !miso_oe; endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("miso still driven after frame end");
    property p_oe_start;
        $rose(miso_oe) |-> !cs_n && ((cmd_sh == ASP_CMD_FIFO && rises >= 8'h08)
            || (cmd_sh == ASP_CMD_READ && rises >= 8'h10));
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("miso driven before read data");
    property p_unknown_quiet;
        !cs_n && rises >= 8'h08 && cmd_sh != ASP_CMD_WRITE && cmd_sh != ASP_CMD_READ
            && cmd_sh != ASP_CMD_FIFO |-> !miso_oe;
    endproperty
    a_unknown_quiet: assert property (p_unknown_quiet)
        else $error("miso driven after unknown command");
    property p_write_quiet;
        !cs_n && rises >= 8'h08 && cmd_sh == ASP_CMD_WRITE |-> !miso_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("miso driven during write");
    property p_frame_start; $fell(cs_n) |-> !sclk && !miso_oe; endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame opened with clock high or miso driven");
    c_fifo: cover property ($rose(miso_oe) && cmd_sh == ASP_CMD_FIFO);
    c_read: cover property ($rose(miso_oe) && cmd_sh == ASP_CMD_READ);
    c_write: cover property (rises == 8'h18 && cmd_sh == ASP_CMD_WRITE);
    c_unknown: cover property (rises == 8'h08 && cmd_sh == 8'h55);
endmodule // asp_link_asserts

// >>> sim/accel_spi_command_port_tb.sv
// Testbench joining the master and device ends over one serial link.
`timescale 1ns/10ps
module accel_spi_command_port_tb;
    import asp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_we, reg_re, smp_ready, drdy, wdata_take, rdata_valid, busy;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rdata;
    logic [15:0] smp_data = 16'h0000;
    logic smp_valid = 1'b0;
    logic drdy_set = 1'b0;
    logic start = 1'b0;
    logic rd_on = 1'b0;
    logic [7:0] cmd_byte = 8'h00, addr_byte = 8'h00, nbytes = 8'h01, wdata = 8'h00;
    logic [7:0] regs [64];
    logic [7:0] bad [4] = '{8'h00, 8'h0C, 8'h55, 8'hFF};
    logic [7:0] drd [6] = '{8'h08, 8'h0A, 8'h0E, 8'h15, 8'h0B, 8'h16};
    logic [15:0] exp_rd[$], exp_wr[$], smp_q[$];
    logic [7:0] wq[$];
    int failures = 0, tests_run = 0, strobes = 0, k;
    asp_if link_if ();
    asp_dev #(.DEPTH(ASP_FIFO_DEPTH), .CLEAR_CYC(20)) asp_dev_inst (.clock(clock), .rst(rst),
        .ce(1'b1), .link(link_if.dev), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .smp_data(smp_data),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .drdy_set(drdy_set), .drdy(drdy));
    asp_mst #(.DIV(ASP_SCLK_DIV)) asp_mst_inst (.clock(clock), .rst(rst), .ce(1'b1),
        .link(link_if.mst), .start(start), .cmd_byte(cmd_byte), .addr_byte(addr_byte),
        .nbytes(nbytes), .wdata(wdata), .wdata_take(wdata_take), .rdata(rdata),
        .rdata_valid(rdata_valid), .busy(busy));
    asp_link_asserts asp_link_asserts_inst (.clock(clock), .rst(rst), .cs_n(link_if.cs_n),
        .sclk(link_if.sclk), .mosi(link_if.mosi), .miso_o(link_if.miso_o),
        .miso_oe(link_if.miso_oe));
    // Register stub answers reads straight from its array, as the device expects.
    assign reg_rdata = regs[reg_addr];
    initial begin
        forever #10 clock = ~clock;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Register stub, result monitor, write data supply and sample source.
    always @(posedge clock) begin
        if (reg_we) regs[reg_addr] <= reg_wdata;
        if (reg_we) check("write", {2'b00, reg_addr, reg_wdata},
            exp_wr.size() ? exp_wr.pop_front() : 16'hFFFF);
        if (reg_we || reg_re) strobes++;
        if (rdata_valid && rd_on) check("read", {8'h00, rdata},
            exp_rd.size() ? exp_rd.pop_front() : 16'hFFFF);
        if (wdata_take) wdata <= wq.size() ? wq.pop_front() : 8'h00;
        if (smp_valid && smp_ready) smp_q.push_back(smp_data);
        if (smp_valid && smp_ready) smp_data <= 16'($urandom);
    end
    // One framed command; the model of the expected results is built first.
    task frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] n);
        logic [5:0] p;
        logic [7:0] d;
        logic [15:0] s;
        p = (a > 8'h3F) ? 6'h3F : a[5:0];
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (c == ASP_CMD_WRITE) wq.push_back(d);
            if (c == ASP_CMD_WRITE && p != 6'h3F) exp_wr.push_back({2'b00, p, d});
            if (c == ASP_CMD_READ) exp_rd.push_back({8'h00, regs[p]});
            if (c == ASP_CMD_FIFO && i % 2 == 0) s = smp_q.pop_front();
            if (c == ASP_CMD_FIFO) exp_rd.push_back({8'h00, (i % 2) ? s[15:8] : s[7:0]});
            p = (p == 6'h3F) ? p : p + 6'h01;
        end
        rd_on = (c == ASP_CMD_READ || c == ASP_CMD_FIFO);
        @(posedge clock);
        start <= 1'b1;
        cmd_byte <= c;
        addr_byte <= a;
        nbytes <= n;
        wdata <= wq.size() ? wq.pop_front() : 8'h00;
        @(posedge clock);
        start <= 1'b0;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while ((busy || k < 3) && k < 8000);
        check("timeout", 16'(k == 8000), 16'h0000);
        if (k == 8000) print_verdict();
        repeat (6) @(negedge clock);
        rd_on = 1'b0;
        wq.delete();
        check("rd_left", 16'(exp_rd.size()), 16'h0000);
        check("wr_left", 16'(exp_wr.size()), 16'h0000);
    endtask
    // Main sequence.
    initial begin
        void'($urandom(99672));
        for (int i = 0; i < 64; i++) regs[i] = (i == 63) ? 8'h00 : 8'($urandom);
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        frame(ASP_CMD_WRITE, 8'h3C, 8'd6);
        frame(ASP_CMD_WRITE, 8'h80, 8'd2);
        frame(ASP_CMD_READ, 8'h3B, 8'd6);
        frame(ASP_CMD_READ, 8'hC5, 8'd2);
        frame(ASP_CMD_READ, 8'($urandom % 47), 8'd4);
        $display("Register burst test done");
        strobes = 0;
        foreach (bad[i]) frame(bad[i], 8'h01, 8'd2);
        check("strobes", 16'(strobes), 16'h0000);
        $display("Unknown command test done");
        foreach (drd[i]) begin
            @(posedge clock);
            drdy_set <= 1'b1;
            @(posedge clock);
            drdy_set <= 1'b0;
            frame(ASP_CMD_READ, drd[i], 8'd1);
            repeat (25) @(negedge clock);
            check("drdy", {15'h0, drdy},
                {15'h0, drd[i] == 8'h0B || drd[i] == 8'h16});
        end
        $display("Data ready test done");
        @(posedge clock);
        smp_data <= 16'($urandom);
        smp_valid <= 1'b1;
        // Ready drops for a cycle after each handshake, so wait on the accepted count.
        for (k = 0; k < 300 && smp_q.size() < ASP_FIFO_DEPTH; k++) @(negedge clock);
        @(posedge clock);
        smp_valid <= 1'b0;
        repeat (2) @(negedge clock);
        check("full", {15'h0, smp_ready}, 16'h0000);
        check("depth", 16'(smp_q.size()), 16'(ASP_FIFO_DEPTH));
        frame(ASP_CMD_FIFO, 8'h00, 8'(1 + 2 * ($urandom % 3)));
        frame(ASP_CMD_FIFO, 8'h00, 8'd4);
        frame(ASP_CMD_FIFO, 8'h00, 8'(2 * smp_q.size()));
        check("drained", {15'h0, smp_ready}, 16'h0001);
        $display("Sample stream test done");
        print_verdict();
    end
endmodule // accel_spi_command_port_tb
